/* pkg/rdac_params.svh */
`ifndef RDAC_PARAMS_SVH
`define RDAC_PARAMS_SVH

// reset values
`define RDAC_RTS_N_RST      1'b1
`define RDAC_RX_EN_RST      1'b0
// field positions of a receive fifo word
`define RDAC_WORD_PERR_POS  8
`define RDAC_WORD_DATA_MSB  7
// fifo shape
`define RDAC_FIFO_WIDTH     9
`define RDAC_FIFO_DEPTH     4

`endif

/* pkg/rdac_pkg.sv */
package rdac_pkg;

  // direction control states, gray order along idle -> busy
  typedef enum logic [0:0] {
    DIR_IDLE = 1'h0,
    DIR_BUSY = 1'h1
  } rdac_dir_state_type;

  // what the receive filter does with one character
  typedef enum logic [1:0] {
    RX_DROP  = 2'h0,
    RX_STORE = 2'h1,
    RX_ADDR  = 2'h3
  } rdac_rx_action_type;

endpackage : rdac_pkg

/* core/rdac_top.sv */
`timescale 1ns/1ps
`include "rdac_params.svh"

// ----------------------------------------------------------------
// small receive fifo
// ----------------------------------------------------------------
module rdac_fifo #(
  parameter int WIDTH = `RDAC_FIFO_WIDTH,
  parameter int DEPTH = `RDAC_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad_shape
    $error("rdac_fifo: depth must be a power of two of at least 2");
  end
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  logic             push;
  logic             pop;
  assign in_ready  = (wr_q - rd_q) != (AW+1)'(DEPTH);
  assign out_valid = wr_q != rd_q;
  assign out_data  = mem_q[rd_q[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= '0;
    end else if (push) begin
      wr_q <= wr_q + (AW+1)'(1);
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_q <= '0;
    end else if (pop) begin
      rd_q <= rd_q + (AW+1)'(1);
    end
  end
endmodule : rdac_fifo

module rdac_top #(
  parameter int FIFO_DEPTH = `RDAC_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // configuration bits
  input  wire logic       modem_rts_bit,
  input  wire logic       hw_flow_en,
  input  wire logic       flow_rts_n,
  input  wire logic       auto_dir_en,
  input  wire logic       dir_invert,
  input  wire logic       multidrop_en,
  input  wire logic       special_char_en,
  input  wire logic [7:0] station_addr,
  input  wire logic       line_int_en,
  // host receiver control and status reads
  input  wire logic       rx_enable_set,
  input  wire logic       rx_enable_clr,
  input  wire logic       line_status_read,
  // transmitter state
  input  wire logic       tx_wr,
  input  wire logic       tx_fifo_empty,
  input  wire logic       tx_shift_empty,
  // received characters
  input  wire logic       rx_char_valid,
  input  wire logic [7:0] rx_char_data,
  input  wire logic       rx_char_parity,
  input  wire logic       rx_parity_err,
  // receive fifo read side
  input  wire logic       rd_ready,
  output logic            rd_valid,
  output logic      [7:0] rd_data,
  output logic            rd_perr,
  // status and pin
  output logic            rts_n_q,
  output logic            rx_enabled_q,
  output logic            line_int_q,
  output logic            rx_overrun_q
);
  if (FIFO_DEPTH < 2) begin : g_bad_depth
    $error("rdac_top: receive fifo too shallow");
  end
  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_q;
  logic       rst_n;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];
  // ----------------------------------------------------------------
  // direction control
  // ----------------------------------------------------------------
  rdac_pkg::rdac_dir_state_type dir_q;
  rdac_pkg::rdac_dir_state_type dir_d;
  logic                         tx_done;
  logic                         rts_n_d;
  assign tx_done = tx_fifo_empty && tx_shift_empty;
  always_comb begin
    dir_d = dir_q;
    case (dir_q)
      rdac_pkg::DIR_IDLE: begin
        if (tx_wr || !tx_done) begin
          dir_d = rdac_pkg::DIR_BUSY;
        end
      end
      rdac_pkg::DIR_BUSY: begin
        if (tx_done && !tx_wr) begin
          dir_d = rdac_pkg::DIR_IDLE;
        end
      end
      default: dir_d = rdac_pkg::DIR_IDLE;
    endcase
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dir_q <= rdac_pkg::DIR_IDLE;
    end else begin
      dir_q <= dir_d;
    end
  end
  always_comb begin
    if (auto_dir_en) begin
      // busy drives low, or high when inverted
      rts_n_d = (dir_d == rdac_pkg::DIR_BUSY) ? dir_invert : !dir_invert;
    end else if (hw_flow_en) begin
      rts_n_d = flow_rts_n;
    end else begin
      rts_n_d = !modem_rts_bit;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rts_n_q <= `RDAC_RTS_N_RST;
    end else begin
      rts_n_q <= rts_n_d;
    end
  end
  // ----------------------------------------------------------------
  // receive filter
  // ----------------------------------------------------------------
  rdac_pkg::rdac_rx_action_type act;
  logic                         addr_hit;
  logic                         push;
  logic                         push_perr;
  logic                         fifo_ready;
  logic                         fifo_valid;
  logic [8:0]                   fifo_out;
  assign addr_hit = rx_char_data == station_addr;
  always_comb begin
    act = rdac_pkg::RX_DROP;
    if (!rx_char_valid) begin
      act = rdac_pkg::RX_DROP;
    end else if (!multidrop_en) begin
      act = rdac_pkg::RX_STORE;
    end else if (!rx_char_parity) begin
      // data character
      act = rx_enabled_q ? rdac_pkg::RX_STORE : rdac_pkg::RX_DROP;
    end else if (!special_char_en || addr_hit) begin
      act = rdac_pkg::RX_ADDR;
    end else begin
      act = rdac_pkg::RX_DROP;
    end
  end
  assign push      = act != rdac_pkg::RX_DROP;
  // address characters carry the parity bit in the error position
  assign push_perr = (act == rdac_pkg::RX_ADDR) ? rx_char_parity : rx_parity_err;
  rdac_fifo #(
    .WIDTH (`RDAC_FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) rdac_fifo_inst (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (push),
    .in_ready  (fifo_ready),
    .in_data   ({push_perr, rx_char_data}),
    .out_valid (fifo_valid),
    .out_ready (!rd_valid || rd_ready),
    .out_data  (fifo_out)
  );
  // receiver enable: hardware decisions win over host pulses
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_enabled_q <= `RDAC_RX_EN_RST;
    end else if (multidrop_en && special_char_en && rx_char_valid && rx_char_parity) begin
      rx_enabled_q <= addr_hit;
    end else if (rx_enable_set) begin
      rx_enabled_q <= 1'b1;
    end else if (rx_enable_clr) begin
      rx_enabled_q <= 1'b0;
    end
  end
  // line status interrupt: set wins over read clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      line_int_q <= 1'b0;
    end else if (push && push_perr && line_int_en) begin
      line_int_q <= 1'b1;
    end else if (line_status_read) begin
      line_int_q <= 1'b0;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_overrun_q <= 1'b0;
    end else begin
      rx_overrun_q <= push && !fifo_ready;
    end
  end
  // ----------------------------------------------------------------
  // registered read port
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_valid <= 1'b0;
      rd_data  <= 8'h00;
      rd_perr  <= 1'b0;
    end else if (!rd_valid || rd_ready) begin
      rd_valid <= fifo_valid;
      rd_data  <= fifo_out[`RDAC_WORD_DATA_MSB:0];
      rd_perr  <= fifo_out[`RDAC_WORD_PERR_POS];
    end
  end
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_manual_rts_bit: assert property (!auto_dir_en && !hw_flow_en |=> rts_n_q == !$past(modem_rts_bit))
    else $error("rts does not follow modem bit");
  a_flow_rts_pin: assert property (!auto_dir_en && hw_flow_en |=> rts_n_q == $past(flow_rts_n))
    else $error("rts does not follow flow control");
  a_auto_rts_low: assert property (auto_dir_en && !dir_invert && tx_wr |=> !rts_n_q)
    else $error("rts not asserted on transmit write");
  a_inv_rts_high: assert property (auto_dir_en && dir_invert && tx_wr |=> rts_n_q)
    else $error("inverted rts not high on transmit write");
  a_hold_until_empty: assert property (auto_dir_en && !dir_invert && !tx_shift_empty ##1 auto_dir_en && !dir_invert
                                       |-> !rts_n_q)
    else $error("rts released before shifter empty");
  a_md_data_drop: assert property (rx_char_valid && multidrop_en && !rx_char_parity && !rx_enabled_q |-> !push)
    else $error("data stored while receiver disabled");
  a_md_addr_store: assert property (rx_char_valid && multidrop_en && !special_char_en && rx_char_parity
                                    && fifo_ready && line_int_en |-> push && push_perr ##1 line_int_q)
    else $error("address byte not stored with error");
  a_md_keep_enabled: assert property (rx_char_valid && multidrop_en && !special_char_en && rx_char_parity
                                      && rx_enabled_q && !rx_enable_clr |=> rx_enabled_q)
    else $error("receiver lost enable on address");
  a_auto_data_drop: assert property (rx_char_valid && multidrop_en && special_char_en && !rx_char_parity
                                     && !rx_enabled_q |-> !push)
    else $error("data stored before address match");
  a_auto_match_on: assert property (rx_char_valid && multidrop_en && special_char_en && rx_char_parity
                                    && addr_hit |-> push_perr ##1 rx_enabled_q)
    else $error("matching address did not enable receiver");
  a_auto_miss_off: assert property (rx_char_valid && multidrop_en && special_char_en && rx_char_parity
                                    && !addr_hit |-> !push ##1 !rx_enabled_q)
    else $error("foreign address not discarded");
endmodule : rdac_top

/* verif/rdac_line_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// rs-485 line and remote stations
// ----------------------------------------
module rdac_line_model (
  // clock
  input  wire logic       clk,
  // commands from the bench
  input  wire logic       snd,
  input  wire logic [8:0] snd_word,
  input  wire logic       snd_perr,
  input  wire logic       slow,
  // transmit activity
  input  wire logic       tx_wr,
  // toward the block
  output logic            rx_char_valid,
  output logic      [7:0] rx_char_data,
  output logic            rx_char_parity,
  output logic            rx_parity_err,
  output logic            tx_fifo_empty,
  output logic            tx_shift_empty
);
  logic [4:0] left_q;

  initial begin
    left_q = 5'h00;
    rx_char_valid = 1'b0;
    {rx_char_data, rx_char_parity, rx_parity_err} = 10'h0a5;
  end

  // idle lines toggle so stale values never pass for a character
  always @(posedge clk) begin
    rx_char_valid  <= snd;
    rx_char_data   <= snd ? snd_word[7:0] : ~rx_char_data;
    rx_char_parity <= snd ? snd_word[8] : ~rx_char_parity;
    rx_parity_err  <= snd ? snd_perr : ~rx_parity_err;
  end

  // each write keeps the line busy, stop bits last
  always @(posedge clk) begin
    if (tx_wr)
      left_q <= slow ? 5'h14 : 5'h04;
    else if (left_q != 5'h00)
      left_q <= left_q - 5'h01;
  end

  assign tx_fifo_empty  = (left_q < 5'h03);
  assign tx_shift_empty = (left_q == 5'h00);
endmodule : rdac_line_model

/* verif/rdac_top_tb.sv */
`timescale 1ns/1ps
module rdac_top_tb;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic        clk, rst_b, modem_rts_bit, hw_flow_en, flow_rts_n, auto_dir_en, dir_invert;
  logic        multidrop_en, special_char_en, line_int_en, tx_wr, rd_ready, snd, snd_perr;
  logic        tx_fifo_empty, tx_shift_empty, rx_char_valid, rx_char_parity, rx_parity_err;
  logic        rd_valid, rd_perr, rts_n_q, rx_enabled_q, line_int_q, rx_overrun_q, slow, exp_en;
  logic [2:0]  hp;
  logic [7:0]  station_addr, rx_char_data, rd_data;
  logic [8:0]  snd_word;
  logic [31:0] r;
  logic [8:0]  exp_q[$];
  int          n_fail, n_compared, n_ovr;

  rdac_top rdac_top_inst (
    .clk, .rst_b, .modem_rts_bit, .hw_flow_en, .flow_rts_n, .auto_dir_en, .dir_invert,
    .multidrop_en, .special_char_en, .station_addr, .line_int_en, .rx_enable_set(hp[0]),
    .rx_enable_clr(hp[1]), .line_status_read(hp[2]), .tx_wr, .tx_fifo_empty, .tx_shift_empty,
    .rx_char_valid, .rx_char_data, .rx_char_parity, .rx_parity_err, .rd_ready, .rd_valid,
    .rd_data, .rd_perr, .rts_n_q, .rx_enabled_q, .line_int_q, .rx_overrun_q);
  rdac_line_model rdac_line_model_inst (
    .clk, .snd, .snd_word, .snd_perr, .slow, .tx_wr, .rx_char_valid, .rx_char_data,
    .rx_char_parity, .rx_parity_err, .tx_fifo_empty, .tx_shift_empty);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle

  task automatic host(input logic [2:0] v);
    @(posedge clk);
    hp <= v;
    @(posedge clk);
    hp <= 3'h0;
    settle(2);
  endtask : host

  // returns {stored, receiver enable afterwards}
  function automatic logic [1:0] rx_act(input logic [8:0] w, input logic en);
    if (!multidrop_en) return {1'b1, en};
    if (!special_char_en) return {w[8] | en, en};
    if (w[8]) return {2{w[7:0] == station_addr}};
    return {en, en};
  endfunction : rx_act

  task automatic send(input logic [8:0] w, input logic pe);
    logic [1:0] a;
    @(posedge clk);
    a = rx_act(w, exp_en);
    snd <= 1'b1;
    snd_word <= w;
    snd_perr <= pe;
    @(posedge clk);
    snd <= 1'b0;
    exp_en = a[0];
    if (a[1]) exp_q.push_back({(multidrop_en & w[8]) | pe, w[7:0]});
    settle(2);
    check(rx_enabled_q, exp_en);
  endtask : send

  task automatic drain;
    logic [8:0] w;
    int k;
    while (exp_q.size() != 0) begin
      w = exp_q.pop_front();
      for (k = 0; k < 20 && rd_valid !== 1'b1; k++) settle(1);
      check({rd_perr, rd_data}, w);
      @(posedge clk);
      rd_ready <= 1'b1;
      @(posedge clk);
      rd_ready <= 1'b0;
      #1;
    end
    settle(4);
    check(rd_valid, 1'b0);
  endtask : drain

  task automatic final_report;
    $display("compared=%0d failed=%0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : final_report

  always @(posedge clk) if (rx_overrun_q === 1'b1) n_ovr++;

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    #200000;
    n_fail++;
    final_report();
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    {modem_rts_bit, hw_flow_en, flow_rts_n, auto_dir_en, dir_invert, multidrop_en} = '0;
    {special_char_en, line_int_en, tx_wr, rd_ready, snd, snd_perr, slow, exp_en, rst_b} = '0;
    {hp, station_addr, snd_word} = '0;
    r = $urandom(92883);
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    settle(3);
    check({rts_n_q, rx_enabled_q, line_int_q, rd_valid}, 9'h008);
    for (int i = 0; i < 8; i++) begin
      r = $urandom;
      @(posedge clk);
      {hw_flow_en, flow_rts_n, modem_rts_bit} <= r[2:0];
      settle(2);
      check(rts_n_q, {r[2] ? r[1] : ~r[0]});
    end
    hw_flow_en <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      {auto_dir_en, modem_rts_bit, dir_invert, slow} <= {2'b11, i[0], i[1]};
      settle(2);
      check(rts_n_q, {~i[0]});
      @(posedge clk);
      tx_wr <= 1'b1;
      @(posedge clk);
      tx_wr <= i[1];
      #1;
      check(rts_n_q, {i[0]});
      @(posedge clk);
      tx_wr <= 1'b0;
      for (int k = 0; k < 40 && tx_shift_empty !== 1'b1; k++) settle(1);
      check(rts_n_q, {i[0]});
      settle(1);
      check(rts_n_q, {~i[0]});
    end
    @(posedge clk);
    {auto_dir_en, multidrop_en, line_int_en} <= 3'h3;
    send({1'b0, r[7:0]}, 1'b0);
    send({1'b1, r[15:8]}, 1'b0);
    check(line_int_q, 1'b1);
    host(3'h4);
    check(line_int_q, 1'b0);
    drain();
    host(3'h1);
    exp_en = 1'b1;
    for (int i = 0; i < 3; i++) send({1'b0, 8'($urandom)}, 1'b0);
    send({1'b1, r[23:16]}, 1'b0);
    check(line_int_q, 1'b1);
    drain();
    host(3'h6);
    check(line_int_q, 1'b0);
    exp_en = 1'b0;
    station_addr <= r[31:24];
    special_char_en <= 1'b1;
    send({1'b1, r[31:24] ^ 8'h5a}, 1'b0);
    send({1'b0, r[31:24]}, 1'b0);
    send({1'b1, r[31:24]}, 1'b0);
    check(line_int_q, 1'b1);
    send({1'b0, r[7:0]}, 1'b0);
    send({1'b1, r[31:24] ^ 8'h01}, 1'b0);
    send({1'b0, r[15:8]}, 1'b0);
    drain();
    @(posedge clk);
    multidrop_en <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      r = $urandom;
      @(posedge clk);
      {snd_perr, snd_word, snd} <= {r[9:0], 1'b1};
      if (i < 5) exp_q.push_back({r[9], r[7:0]});
    end
    @(posedge clk);
    snd <= 1'b0;
    settle(4);
    check(n_ovr[8:0], 9'h001);
    drain();
    final_report();
  end
endmodule : rdac_top_tb
